//--- core/mcs_regs.svh
// Purpose: register map, field positions, reset values and timing counts
// Assumes: 100 MHz system clock, 32-bit classic wishbone register window
// Notes: byte addresses, one aligned word per register
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH
// register byte offsets
`define MCS_OFS_STATUS 4'h0
`define MCS_OFS_FLAGS 4'h4
`define MCS_OFS_MASK 4'h8
`define MCS_OFS_CTRL 4'hc
// status fields
`define MCS_ST_NOT_READY 0
`define MCS_ST_LOW_POWER 1
`define MCS_ST_SERIAL_EN 2
`define MCS_ST_RESET_SEEN 3
// control fields
`define MCS_CTRL_PDOWN 0
// flag and mask word width
`define MCS_FLAG_W 13
// reset values
`define MCS_MASK_RST 13'h0000
`define MCS_CTRL_RST 1'b0
`define MCS_PIN_RST 17'h0001b
// 2-wire address pattern, upper seven bits
`define MCS_DEV_ADDR 7'h50
// timing, figures in their own unit
`define MCS_CLK_KHZ 100000
`define MCS_T_INIT_MS 2000
`define MCS_T_RESET_US 2
`define MCS_INIT_CYC (`MCS_T_INIT_MS * `MCS_CLK_KHZ)
`define MCS_RESET_CYC (`MCS_T_RESET_US * `MCS_CLK_KHZ / 1000)
`endif

//--- core/mcs_pkg.sv
// Purpose: shared types of the module control and status supervisor
// Assumes: nothing beyond the register header
// Notes: flag word layout is fixed by mcs_cond_type
package mcs_pkg;
  typedef struct packed {
    logic data_ready;
    logic [3:0] other;
    logic [3:0] tx_fault;
    logic [3:0] rx_los;
  } mcs_cond_type;
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_INIT = 2'b01,
    ST_READY = 2'b10
  } mcs_state_type;
endpackage

//--- core/mcs_top.sv
// Purpose: control and status supervisor of a four-lane pluggable module
// Assumes: wishbone master is the module's management logic; pins are asynchronous
// Notes: flag clears and mask or power-down changes commit on the serial clock
// What this block does
// [RL1] after power-on or hot plug reach full function within 2000 ms
// [RL2] reset pin low longer than 2 us is a reset request
// [RL3] answer the serial bus no later than 2000 ms after power-on
// [RL4] within 2000 ms clear monitor-not-ready and assert the interrupt request
// [RL5] after reset pin rises become fully functional within 2000 ms
// [RL6] full function means interrupt asserted by monitor-not-ready clearing
// [RL7] low-power request pin lowers power within 100 us
// [RL8] interrupt condition drives interrupt request low within 200 ms
// [RL9] flags clear on read; interrupt releases within 500 us after that
// [RL10] receive signal loss sets its flag and interrupt within 100 ms
// [RL11] transmit fault sets its flag and interrupt within 200 ms
// [RL12] any other condition sets its flag and interrupt within 200 ms
// [RL13] setting a mask bit inhibits that flag's interrupt within 100 ms
// [RL14] clearing a mask bit lets that flag interrupt again within 100 ms
// [RL15] module select asserted lets the serial bus answer within 100 us
// [RL16] module select released stops serial bus answers within 100 us
// [RL17] setting power-down bit enters low power within 100 ms
// [RL18] clearing power-down bit returns to full function within 300 ms
// [RL19] clear-on-read timing starts at falling serial clock after stop
// [RL20] mask and power-down timing starts at falling serial clock after stop
// [RL21] serial bus answers at seven-bit address 1010000 plus direction bit
// [RL22] host reads the flags after an interrupt to find its cause
// [RL23] interrupt stays asserted while any unmasked flag is set
// [RL24] each flag latches its condition until the host reads it
//
// Register access over Wishbone and the address map were chosen for this implementation.
`include "mcs_regs.svh"

module mcs_top #(
  parameter logic [27:0] INIT_CYCLES = 28'(`MCS_INIT_CYC) // init wait in clocks
) (
  input wire logic clk, // system clock, 100 MHz
  input wire logic reset, // async reset, active high (power-on)
  input wire logic [31:0] wb_adr_i, // wishbone byte address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic wb_we_i, // wishbone write enable
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic module_reset_low, // reset pin, active low
  input wire logic module_select_low, // select pin, active low
  input wire logic low_power_request, // low-power pin, active high
  input wire logic serial_clock, // 2-wire clock pin level
  input wire logic serial_data, // 2-wire data pin level
  input wire mcs_pkg::mcs_cond_type cond_in, // raw conditions, data_ready unused
  output logic interrupt_request_low, // interrupt request, active low
  output logic low_power_mode, // power stage at lower level
  output logic serial_enable, // serial slave may answer
  output logic serial_addr_hit, // address byte matched this device
  output logic serial_addr_read, // direction bit of matched address
  output logic monitor_not_ready // monitor data not yet valid
);
  import mcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // register decode, shared by the read and write paths
  function automatic logic [1:0] reg_index(input logic [31:0] adr);
    reg_index = adr[3:2];
  endfunction

  function automatic logic reg_mapped(input logic [31:0] adr);
    reg_mapped = (adr[31:4] == 28'h0000000) && (adr[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [16:0] pin_raw;
  logic [16:0] sync1_r;
  logic [16:0] sync2_r;
  logic [16:0] sync3_r;
  assign pin_raw = {cond_in[11:0], serial_data, serial_clock, low_power_request,
                    module_select_low, module_reset_low};

  // two stages, then one more for edge finding
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_r <= `MCS_PIN_RST;
      sync2_r <= `MCS_PIN_RST;
      sync3_r <= `MCS_PIN_RST;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  logic rst_pin_n;
  logic sel_pin_n;
  logic lp_pin;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [11:0] cond_s;
  assign rst_pin_n = sync2_r[0];
  assign sel_pin_n = sync2_r[1];
  assign lp_pin = sync2_r[2];
  assign scl = sync2_r[3];
  assign sda = sync2_r[4];
  assign cond_s = sync2_r[16:5];
  assign scl_rise = scl & ~sync3_r[3];
  assign scl_fall = ~scl & sync3_r[3];
  assign bus_start = scl & sync3_r[3] & ~sda & sync3_r[4];
  assign bus_stop = scl & sync3_r[3] & sda & ~sync3_r[4];

  ////////////////////////////////////////////////////////////////////////////////
  // commit point: first falling serial clock after a stop
  logic stop_seen_r;
  logic commit_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stop_seen_r <= 1'b0;
      commit_r <= 1'b0;
    end else begin
      commit_r <= stop_seen_r & scl_fall; // RL19 RL20
      if (bus_stop) begin
        stop_seen_r <= 1'b1;
      end else if (scl_fall) begin
        stop_seen_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset pin filter: a low of at least the minimum pulse is a reset request
  logic [7:0] low_cnt_r;
  logic reset_req_r;
  logic reset_seen_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt_r <= 8'h00;
      reset_req_r <= 1'b0;
    end else if (rst_pin_n) begin
      low_cnt_r <= 8'h00;
      reset_req_r <= 1'b0;
    end else if (low_cnt_r == 8'(`MCS_RESET_CYC)) begin
      reset_req_r <= 1'b1; // RL2
    end else begin
      low_cnt_r <= low_cnt_r + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // initialization sequencer
  mcs_state_type state_r;
  logic [27:0] init_cnt_r;
  logic ready_evt;
  assign ready_evt = (state_r == ST_INIT) && (init_cnt_r == INIT_CYCLES);

  // hold while reset requested, restart init on release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_INIT;
      init_cnt_r <= 28'h0000000;
    end else begin
      unique case (state_r)
        ST_HOLD: begin
          init_cnt_r <= 28'h0000000;
          if (rst_pin_n) begin
            state_r <= ST_INIT; // RL5
          end
        end
        ST_INIT: begin
          if (reset_req_r) begin
            state_r <= ST_HOLD;
          end else if (ready_evt) begin
            state_r <= ST_READY; // RL1 RL4
          end else begin
            init_cnt_r <= init_cnt_r + 28'h0000001;
          end
        end
        ST_READY: begin
          if (reset_req_r) begin
            state_r <= ST_HOLD;
          end
        end
        default: begin
          state_r <= ST_HOLD;
        end
      endcase
    end
  end

  // sticky note that a pin reset happened, cleared by reading status
  logic status_rd;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reset_seen_r <= 1'b0;
    end else if (reset_req_r) begin
      reset_seen_r <= 1'b1;
    end else if (status_rd) begin
      reset_seen_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone slave, answers one cycle after the strobe
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [1:0] idx;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign idx = reg_index(wb_adr_i);
  assign bus_wr = bus_req & wb_we_i & reg_mapped(wb_adr_i);
  assign bus_rd = bus_req & ~wb_we_i & reg_mapped(wb_adr_i);
  assign status_rd = bus_rd && (idx == reg_index(32'(`MCS_OFS_STATUS)));

  mcs_cond_type flags_r;
  logic [12:0] mask_r;
  logic [12:0] mask_eff_r;
  logic pdown_r;
  logic pdown_eff_r;

  // read mux, unmapped addresses read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (bus_rd) begin
        unique case (idx)
          reg_index(32'(`MCS_OFS_STATUS)): begin
            wb_dat_o[`MCS_ST_NOT_READY] <= monitor_not_ready;
            wb_dat_o[`MCS_ST_LOW_POWER] <= low_power_mode;
            wb_dat_o[`MCS_ST_SERIAL_EN] <= serial_enable;
            wb_dat_o[`MCS_ST_RESET_SEEN] <= reset_seen_r;
          end
          reg_index(32'(`MCS_OFS_FLAGS)): wb_dat_o[12:0] <= flags_r;
          reg_index(32'(`MCS_OFS_MASK)): wb_dat_o[12:0] <= mask_r;
          reg_index(32'(`MCS_OFS_CTRL)): wb_dat_o[`MCS_CTRL_PDOWN] <= pdown_r;
        endcase
      end
    end
  end

  // software view of mask and power-down, byte-lane gated
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_r <= `MCS_MASK_RST;
      pdown_r <= `MCS_CTRL_RST;
    end else if (bus_wr) begin
      if (idx == reg_index(32'(`MCS_OFS_MASK))) begin
        if (wb_sel_i[0]) begin
          mask_r[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          mask_r[12:8] <= wb_dat_i[12:8];
        end
      end
      if (idx == reg_index(32'(`MCS_OFS_CTRL)) && wb_sel_i[0]) begin
        pdown_r <= wb_dat_i[`MCS_CTRL_PDOWN];
      end
    end
  end

  // written values take effect at the commit point
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_eff_r <= `MCS_MASK_RST;
      pdown_eff_r <= `MCS_CTRL_RST;
    end else if (commit_r) begin
      mask_eff_r <= mask_r; // RL13 RL14 RL20
      pdown_eff_r <= pdown_r; // RL17 RL18 RL20
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // flags: latch on condition, clear at commit after being read
  logic [12:0] clr_pend_r;
  logic flag_rd;
  mcs_cond_type flag_set;
  assign flag_rd = bus_rd && (idx == reg_index(32'(`MCS_OFS_FLAGS)));
  assign flag_set = (state_r == ST_READY) ? {ready_evt, cond_s} : {ready_evt, 12'h000};

  // read bits wait for the commit point before clearing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clr_pend_r <= 13'h0000;
    end else if (commit_r) begin
      clr_pend_r <= flag_rd ? flags_r : 13'h0000;
    end else if (flag_rd) begin
      clr_pend_r <= clr_pend_r | flags_r; // RL9
    end
  end

  // a set in the clearing cycle wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flags_r <= 13'h0000;
    end else if (state_r == ST_HOLD) begin
      flags_r <= 13'h0000;
    end else if (commit_r) begin
      flags_r <= (flags_r & ~clr_pend_r) | flag_set; // RL9 RL24
    end else begin
      flags_r <= flags_r | flag_set; // RL10 RL11 RL12 RL24
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt, power and readiness outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      interrupt_request_low <= 1'b1;
      low_power_mode <= 1'b0;
      monitor_not_ready <= 1'b1;
      serial_enable <= 1'b0;
    end else begin
      interrupt_request_low <= ~|(flags_r & ~mask_eff_r); // RL6 RL8 RL23
      low_power_mode <= lp_pin | pdown_eff_r; // RL7 RL17 RL18
      monitor_not_ready <= (state_r != ST_READY); // RL4
      serial_enable <= (state_r == ST_READY) & ~sel_pin_n; // RL3 RL15 RL16
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial address matcher: first byte after a start
  logic [7:0] addr_sh_r;
  logic [3:0] bit_cnt_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      addr_sh_r <= 8'h00;
      bit_cnt_r <= 4'hf;
      serial_addr_hit <= 1'b0;
      serial_addr_read <= 1'b0;
    end else if (bus_start) begin
      bit_cnt_r <= 4'h0;
      serial_addr_hit <= 1'b0;
    end else if (bus_stop || !serial_enable) begin
      bit_cnt_r <= 4'hf;
      serial_addr_hit <= 1'b0; // RL16
    end else if (scl_rise && bit_cnt_r < 4'h8) begin
      addr_sh_r <= {addr_sh_r[6:0], sda};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else if (bit_cnt_r == 4'h8) begin
      serial_addr_hit <= (addr_sh_r[7:1] == `MCS_DEV_ADDR); // RL21
      serial_addr_read <= addr_sh_r[0];
      bit_cnt_r <= 4'hf;
    end
  end
endmodule

//--- verif/mcs_checker.sv
// Purpose: concurrent checks on the supervisor's ports
// Assumes: one clock domain, async reset active high
// Notes: mask writes are tracked so interrupt checks skip masked flags
module mcs_checker #(
  parameter logic [27:0] INIT_CYCLES = 28'h0000032 // init wait in clocks
) (
  input wire logic clk, // system clock
  input wire logic reset, // async reset
  input wire logic [31:0] wb_adr_i, // bus address
  input wire logic [31:0] wb_dat_i, // bus write data
  input wire logic wb_we_i, // bus write
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_ack_o, // bus ack
  input wire logic module_reset_low, // reset pin
  input wire logic module_select_low, // select pin
  input wire logic low_power_request, // low-power pin
  input wire mcs_pkg::mcs_cond_type cond_in, // raw conditions
  input wire logic interrupt_request_low, // interrupt out
  input wire logic low_power_mode, // power level out
  input wire logic serial_enable, // serial answer enable
  input wire logic monitor_not_ready // init pending
);
  timeunit 1ns;
  timeprecision 1ps;
  import mcs_pkg::*;
  logic [12:0] mask_r; // last written mask
  int init_cnt_r; // cycles spent initialising
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////
  // track mask writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_r <= 13'h0000;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == 32'h8) begin
      mask_r <= wb_dat_i[12:0];
    end
  end
  // count cycles of init with the reset pin high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      init_cnt_r <= 0;
    end else if (!monitor_not_ready || !module_reset_low) begin
      init_cnt_r <= 0;
    end else begin
      init_cnt_r <= init_cnt_r + 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acked next cycle");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ready_irq: assert property (
    $fell(monitor_not_ready) && !mask_r[12] |-> ##[0:6] !interrupt_request_low)
    else $error("no interrupt when init completed");
  a_init_bound: assert property (
    init_cnt_r <= INIT_CYCLES + 16)
    else $error("init took too long");
  a_los_irq: assert property (
    !monitor_not_ready && cond_in.rx_los != 4'h0 && mask_r[3:0] == 4'h0
    |-> ##[1:8] !interrupt_request_low)
    else $error("signal loss raised no interrupt");
  a_lp_pin: assert property (
    $rose(low_power_request) |-> ##[1:6] low_power_mode)
    else $error("low-power pin not followed");
  a_sel_on: assert property (
    $fell(module_select_low) && !monitor_not_ready |-> ##[1:6] serial_enable)
    else $error("select did not enable serial");
  a_sel_off: assert property (
    $rose(module_select_low) |-> ##[1:6] !serial_enable)
    else $error("deselect did not stop serial");
  c_ready: cover property ($fell(monitor_not_ready));
  c_lp: cover property ($rose(low_power_mode));
  c_irq: cover property ($fell(interrupt_request_low));
endmodule
bind mcs_top mcs_checker #(.INIT_CYCLES(INIT_CYCLES)) mcs_checker_i (.clk, .reset,
  .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .module_reset_low,
  .module_select_low, .low_power_request, .cond_in, .interrupt_request_low,
  .low_power_mode, .serial_enable, .monitor_not_ready);

//--- verif/mcs_host.sv
// Purpose: host controller model on the 2-wire pins
// Assumes: 160 ns serial clock period, lines pulled up
// Notes: the serial clock stands high between frames
module mcs_host (
  input wire logic clk, // system clock
  output logic scl, // serial clock level
  output logic sda // serial data level
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle lines at their pull-up level
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // wait a number of system clocks
  task automatic wait_clk(int n);
    repeat (n) @(posedge clk);
  endtask
  // start, then eight address bits msb first
  task automatic send_byte(logic [7:0] b);
    sda <= 1'b0;
    wait_clk(8);
    for (int i = 7; i >= 0; i--) begin
      scl <= 1'b0;
      wait_clk(4);
      sda <= b[i];
      wait_clk(4);
      scl <= 1'b1;
      wait_clk(8);
    end
  endtask
  // stop, then the clock fall that commits pending changes
  task automatic commit;
    scl <= 1'b0;
    wait_clk(4);
    sda <= 1'b0;
    wait_clk(4);
    scl <= 1'b1;
    wait_clk(8);
    sda <= 1'b1;
    wait_clk(8);
    scl <= 1'b0;
    wait_clk(8);
    scl <= 1'b1;
    wait_clk(8);
  endtask
endmodule

//--- verif/testbench.sv
// Purpose: self-checking bench of the control and status supervisor
// Assumes: short init count, host model on the 2-wire pins
// Notes: flag clears, mask and power-down need a stop plus clock fall
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import mcs_pkg::*;
  localparam int INIT = 50;
  logic clk = 1'b0, reset = 1'b1, req = 1'b0, wb_we = 1'b0, ack, rst_low = 1'b1;
  logic sel_low = 1'b0, lp_req = 1'b0, scl, sda, irq_low, lpm, sen, hit, hrd, nrdy;
  logic [31:0] wb_adr = 32'h0, wb_dat = 32'h0, rdat, rd;
  mcs_cond_type cond = '0;
  int n_fail = 0, cmp_count = 0;
  mcs_top #(.INIT_CYCLES(28'(INIT))) mcs_top_i (.clk(clk), .reset(reset),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(4'hf), .wb_we_i(wb_we),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_dat_o(rdat), .wb_ack_o(ack),
    .module_reset_low(rst_low), .module_select_low(sel_low),
    .low_power_request(lp_req), .serial_clock(scl), .serial_data(sda), .cond_in(cond),
    .interrupt_request_low(irq_low), .low_power_mode(lpm), .serial_enable(sen),
    .serial_addr_hit(hit), .serial_addr_read(hrd), .monitor_not_ready(nrdy));
  mcs_host mcs_host_i (.clk(clk), .scl(scl), .sda(sda));
  ////////////////////////////////////////////////////////////////
  // clock
  initial forever #5 clk = ~clk;
  // compare and count
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  // one classic bus cycle, read data left in rd
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    req <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    // wait for the answer; only the watchdog ends a hang
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = rdat;
    req <= 1'b0;
    @(posedge clk);
  endtask
  // wait for init to finish, bounded
  task automatic wait_ready;
    for (int i = 0; i < INIT + 40 && nrdy !== 1'b0; i++) @(posedge clk);
    chk("init done", 32'h0, nrdy);
    tick(6);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_init;
    wait_ready();
    chk("irq init", 32'h0, irq_low);
    bus(1'b0, 32'h0, 32'h0);
    chk("status", 32'h4, rd & 32'h7);
    bus(1'b0, 32'h4, 32'h0);
    chk("flags init", 32'h1000, rd);
    host_clear();
    bus(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  // commit pending clears and expect the interrupt released
  task automatic host_clear;
    tick(20);
    chk("irq before stop", 32'h0, irq_low);
    mcs_host_i.commit();
    chk("irq released", 32'h1, irq_low);
  endtask
  task automatic t_los;
    cond.rx_los <= 4'h2;
    cond.other <= 4'h8;
    tick(4);
    cond.rx_los <= 4'h0;
    cond.other <= 4'h0;
    tick(8);
    chk("irq los", 32'h0, irq_low);
    bus(1'b0, 32'h4, 32'h0);
    chk("flags los", 32'h802, rd);
    host_clear();
  endtask
  task automatic t_mask;
    bus(1'b1, 32'h8, 32'h10);
    mcs_host_i.commit();
    cond.tx_fault <= 4'h1;
    tick(10);
    chk("irq masked", 32'h1, irq_low);
    bus(1'b0, 32'h8, 32'h0);
    chk("mask read", 32'h10, rd);
    bus(1'b1, 32'h8, 32'h0);
    mcs_host_i.commit();
    chk("irq unmasked", 32'h0, irq_low);
    cond.tx_fault <= 4'h0;
    bus(1'b0, 32'h4, 32'h0);
    chk("flags tx", 32'h10, rd);
    host_clear();
  endtask
  task automatic t_power;
    lp_req <= 1'b1;
    tick(8);
    chk("lp pin", 32'h1, lpm);
    lp_req <= 1'b0;
    tick(8);
    chk("lp pin off", 32'h0, lpm);
    bus(1'b1, 32'hc, 32'h1);
    bus(1'b0, 32'hc, 32'h0);
    chk("ctrl read", 32'h1, rd);
    tick(20);
    chk("pdown early", 32'h0, lpm);
    mcs_host_i.commit();
    chk("pdown", 32'h1, lpm);
    bus(1'b1, 32'hc, 32'h0);
    mcs_host_i.commit();
    chk("pdown off", 32'h0, lpm);
  endtask
  task automatic t_serial;
    logic [7:0] pat [3] = '{8'ha1, 8'ha0, 8'h44};
    foreach (pat[k]) begin
      mcs_host_i.send_byte(pat[k]);
      tick(4);
      chk("addr hit", {31'h0, pat[k][7:1] == 7'h50}, hit);
      if (pat[k][7:1] == 7'h50) chk("addr dir", {31'h0, pat[k][0]}, hrd);
      mcs_host_i.commit();
    end
    sel_low <= 1'b1;
    tick(8);
    chk("deselect", 32'h0, sen);
    mcs_host_i.send_byte(8'ha0);
    tick(4);
    chk("hit deselected", 32'h0, hit);
    mcs_host_i.commit();
    sel_low <= 1'b0;
    tick(8);
    chk("select", 32'h1, sen);
  endtask
  task automatic t_pin;
    rst_low <= 1'b0;
    tick(100);
    rst_low <= 1'b1;
    tick(10);
    chk("short pulse", 32'h0, nrdy);
    rst_low <= 1'b0;
    tick(230);
    chk("pin reset", 32'h1, nrdy);
    rst_low <= 1'b1;
    wait_ready();
    chk("irq reinit", 32'h0, irq_low);
    bus(1'b0, 32'h0, 32'h0);
    chk("reset seen", 32'hc, rd & 32'hf);
    bus(1'b0, 32'h0, 32'h0);
    chk("reset seen clr", 32'h4, rd & 32'hf);
    bus(1'b0, 32'h4, 32'h0);
    chk("flags reinit", 32'h1000, rd);
    host_clear();
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    tick(20);
    reset <= 1'b0;
    t_init();
    t_los();
    t_mask();
    t_power();
    t_serial();
    t_pin();
    end_of_test();
  end
  // watchdog
  initial begin
    tick(20000);
    n_fail++;
    end_of_test();
  end
endmodule
